// *** logic/byte_buffer.sv ***
// Purpose: small FIFO between the array read stream and the pin shifter
// Assumes: single clock, flush empties it in one cycle
// Notes:   ready is held in a flop so the source sees a clean level
module byte_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_n,
	input  wire logic             i_flush,
	// fill side
	input  wire logic             i_valid,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_ready,
	// drain side
	output logic                  o_valid,
	output logic      [WIDTH-1:0] o_data,
	input  wire logic             i_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             ready_q;
	wire              push = i_valid & ready_q;
	wire              pop  = o_valid & i_ready;

	assign cnt_d   = i_flush ? '0 : cnt_q + (AW+1)'(push) - (AW+1)'(pop);
	assign o_valid = (cnt_q != '0);
	assign o_data  = mem[rd_ptr_q];
	assign o_ready = ready_q;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			cnt_q    <= '0;
			ready_q  <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			ready_q <= (cnt_d != FULL);
			if (i_flush) begin
				wr_ptr_q <= '0;
				rd_ptr_q <= '0;
			end else begin
				if (push)
					wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + AW'(1);
				if (pop)
					rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + AW'(1);
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (push && !i_flush)
			mem[wr_ptr_q] <= i_data;
	end

endmodule // byte_buffer

// *** logic/flash_quad_mode_reset_ctrl.sv ***
// Purpose: command interpreter for quad-mode switching, read parameters,
//          wrapped reads and the two-step software reset of a serial flash
// Assumes: serial clock, chip select and data lanes arrive as async pins
// Notes:   array data enters as a stream; other volatile state is cleared
//          elsewhere on the soft reset pulse
module flash_quad_mode_reset_ctrl #(
	parameter int RECOVERY_CYCLES = flash_cmd_pkg::RST_RECOVERY_CYCLES
) (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	// serial link pins
	input  wire logic        i_cs_n,
	input  wire logic        i_sclk,
	input  wire logic [3:0]  i_io,
	output logic      [3:0]  o_io,
	output logic      [3:0]  o_io_oe,
	// status and configuration
	input  wire logic        i_quad_io_permit_bit,
	output logic             o_four_wire_command_mode,
	output logic      [1:0]  o_dummy_count_field,
	output logic      [1:0]  o_wrap_size_field,
	output logic             o_reset_armed,
	output logic             o_reset_busy,
	output logic             o_soft_reset,
	// array read stream
	output logic             o_rd_en,
	output logic      [23:0] o_rd_addr,
	input  wire logic        i_rd_valid,
	input  wire logic [7:0]  i_rd_data,
	output logic             o_rd_ready
);
	localparam int RCW = $clog2(RECOVERY_CYCLES + 1);
	localparam logic [RCW-1:0] RC_LOAD = RCW'(RECOVERY_CYCLES);

	// pin synchronisers: stage 1 is read only by stage 2
	logic [5:0] pin_s1_q;
	logic [5:0] pin_s2_q;
	logic       sclk_s3_q;
	logic       cs_s3_q;

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_s1_q  <= 6'h01;
			pin_s2_q  <= 6'h01;
			sclk_s3_q <= 1'b0;
			cs_s3_q   <= 1'b1;
		end else begin
			pin_s1_q  <= {i_io, i_sclk, i_cs_n};
			pin_s2_q  <= pin_s1_q;
			sclk_s3_q <= pin_s2_q[1];
			cs_s3_q   <= pin_s2_q[0];
		end
	end

	wire       cs_n_s  = pin_s2_q[0];
	wire [3:0] io_s    = pin_s2_q[5:2];
	wire       rise    = pin_s2_q[1] & ~sclk_s3_q & ~cs_n_s;
	wire       fall    = ~pin_s2_q[1] & sclk_s3_q & ~cs_n_s;
	wire       cs_rise = cs_n_s & ~cs_s3_q;

	// state
	flash_cmd_pkg::phase_e st_q;
	flash_cmd_pkg::phase_e st_d;
	logic [5:0]     cnt_q;
	logic [5:0]     cnt_d;
	logic [31:0]    in_sh_q;
	logic [7:0]     op_q;
	logic           op_done_q;
	logic           quad_q;
	logic [7:0]     rd_param_q;
	logic [1:0]     wrap_q;
	logic           armed_q;
	logic [RCW-1:0] rc_q;
	logic           soft_rst_q;
	logic           busy_q;
	logic           wrap_rd_q;
	logic           rd_en_q;
	logic [23:0]    rd_addr_q;
	logic [5:0]     dummy_q;
	logic [7:0]     out_sh_q;
	logic [5:0]     obit_q;
	logic [3:0]     io_q;
	logic [3:0]     oe_q;

	// decode
	wire [5:0]  lane     = quad_q ? flash_cmd_pkg::LANE_QUAD : flash_cmd_pkg::LANE_SINGLE;
	wire [5:0]  step     = (st_q == flash_cmd_pkg::ST_DUMMY) ? 6'h01 : lane;
	wire [5:0]  cnt_inc  = cnt_q + step;
	wire [31:0] sh_next  = quad_q ? {in_sh_q[27:0], io_s} : {in_sh_q[30:0], io_s[0]};
	wire [7:0]  byte_in  = sh_next[7:0];
	wire        recov    = (rc_q != '0);
	wire        op_full  = (cnt_inc == flash_cmd_pkg::OPCODE_BITS);
	wire [1:0]  dfield   = rd_param_q[flash_cmd_pkg::DUMMY_FIELD_LSB +: 2];
	wire [5:0]  dummy_pg = {3'h0, dfield, 1'h0} + flash_cmd_pkg::DUMMY_MIN;
	wire        is_fast  = (byte_in == flash_cmd_pkg::OP_FAST_READ);
	wire        is_quad  = (byte_in == flash_cmd_pkg::OP_QUAD_IO_RD);
	wire        is_wrap  = (byte_in == flash_cmd_pkg::OP_WRAP_READ);
	wire        rd_op    = is_fast | (quad_q & (is_quad | is_wrap));
	wire        parm_op  = quad_q & (byte_in == flash_cmd_pkg::OP_SET_RD_PARM);
	wire        swrap_op = ~quad_q & (byte_in == flash_cmd_pkg::OP_SET_WRAP);
	wire [5:0]  arg_bits = quad_q ? flash_cmd_pkg::PARAM_BITS : flash_cmd_pkg::WRAP_CMD_BITS;
	wire        arg_done = (st_q == flash_cmd_pkg::ST_ARG) && rise && (cnt_inc == arg_bits);
	wire        op_reset = (op_q == flash_cmd_pkg::OP_RESET);
	wire        do_reset = cs_rise & op_done_q & op_reset & armed_q;
	wire        do_enter = cs_rise & op_done_q & ~quad_q & i_quad_io_permit_bit
	                       & (op_q == flash_cmd_pkg::OP_QUAD_ENTER);
	wire        do_exit  = cs_rise & op_done_q & quad_q
	                       & (op_q == flash_cmd_pkg::OP_QUAD_EXIT);

	// wrapped address stays inside the aligned window
	wire [23:0] wrap_msk = (flash_cmd_pkg::WRAP_BASE_BYTES << wrap_q) - 24'h000001;
	wire [23:0] addr_inc = rd_addr_q + 24'h000001;
	wire [23:0] addr_nxt = wrap_rd_q ? ((rd_addr_q & ~wrap_msk) | (addr_inc & wrap_msk))
	                                 : addr_inc;

	// output shifter source
	logic       buf_valid;
	logic [7:0] buf_data;
	logic       buf_in_ready;
	wire        load     = (obit_q == 6'h00);
	wire        pop      = (st_q == flash_cmd_pkg::ST_DATA) & fall & load & buf_valid;
	wire [7:0]  src      = load ? buf_data : out_sh_q;
	wire [3:0]  io_d     = quad_q ? src[7:4] : {2'h0, src[7], 1'h0};
	wire [7:0]  osh_d    = quad_q ? {src[3:0], 4'h0} : {src[6:0], 1'h0};
	wire        push     = rd_en_q & i_rd_valid & buf_in_ready;

	byte_buffer #(
		.WIDTH (8),
		.DEPTH (2)
	) u_buf (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_flush   (cs_n_s),
		.i_valid   (rd_en_q & i_rd_valid),
		.i_data    (i_rd_data),
		.o_ready   (buf_in_ready),
		.o_valid   (buf_valid),
		.o_data    (buf_data),
		.i_ready   (pop)
	);

	// phase sequencing on sampled rising edges
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		if (cs_n_s) begin
			st_d  = flash_cmd_pkg::ST_CMD;
			cnt_d = 6'h00;
		end else if (rise) begin
			cnt_d = cnt_inc;
			case (st_q)
				flash_cmd_pkg::ST_CMD: begin
					if (op_full) begin
						cnt_d = 6'h00;
						if (recov)
							st_d = flash_cmd_pkg::ST_SKIP;
						else if (rd_op)
							st_d = flash_cmd_pkg::ST_ADDR;
						else if (parm_op || swrap_op)
							st_d = flash_cmd_pkg::ST_ARG;
						else
							st_d = flash_cmd_pkg::ST_SKIP;
					end
				end
				flash_cmd_pkg::ST_ADDR: begin
					if (cnt_inc == flash_cmd_pkg::ADDR_BITS) begin
						cnt_d = 6'h00;
						st_d  = flash_cmd_pkg::ST_DUMMY;
					end
				end
				flash_cmd_pkg::ST_DUMMY: begin
					if (cnt_inc == dummy_q)
						st_d = flash_cmd_pkg::ST_DATA;
				end
				flash_cmd_pkg::ST_ARG: begin
					if (arg_done)
						st_d = flash_cmd_pkg::ST_SKIP;
				end
				default: cnt_d = cnt_q;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q    <= flash_cmd_pkg::ST_CMD;
			cnt_q   <= 6'h00;
			in_sh_q <= 32'h00000000;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			if (rise)
				in_sh_q <= sh_next;
		end
	end

	// completed opcode, held until chip select rises
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			op_q      <= 8'h00;
			op_done_q <= 1'b0;
		end else if (cs_n_s) begin
			op_done_q <= 1'b0;
		end else if (rise && st_q == flash_cmd_pkg::ST_CMD && op_full && !recov) begin
			op_q      <= byte_in;
			op_done_q <= 1'b1;
		end
	end

	// mode, parameters and reset arming
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			quad_q     <= 1'b0;
			rd_param_q <= flash_cmd_pkg::RD_PARAM_RESET;
			wrap_q     <= flash_cmd_pkg::WRAP_SIZE_RESET;
			armed_q    <= 1'b0;
		end else if (do_reset) begin
			quad_q     <= 1'b0;
			rd_param_q <= flash_cmd_pkg::RD_PARAM_RESET;
			wrap_q     <= flash_cmd_pkg::WRAP_SIZE_RESET;
			armed_q    <= 1'b0;
		end else begin
			if (cs_rise && op_done_q)
				armed_q <= (op_q == flash_cmd_pkg::OP_RESET_ARM);
			// only the enable command flips into four-wire mode
			if (do_enter)
				quad_q <= 1'b1;
			else if (do_exit)
				quad_q <= 1'b0;
			if (arg_done && quad_q) begin
				rd_param_q <= byte_in;
				wrap_q     <= byte_in[flash_cmd_pkg::WRAP_FIELD_LSB +: 2];
			end else if (arg_done) begin
				wrap_q <= byte_in[flash_cmd_pkg::SPI_WRAP_LSB +: 2];
			end
		end
	end

	// recovery timer; commands are dropped while it runs
	// busy is taken from the next count so the port stays a flop without lagging
	wire [RCW-1:0] rc_d = do_reset ? RC_LOAD : (recov ? rc_q - RCW'(1) : rc_q);
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rc_q       <= '0;
			soft_rst_q <= 1'b0;
			busy_q     <= 1'b0;
		end else begin
			soft_rst_q <= do_reset;
			rc_q       <= rc_d;
			busy_q     <= (rc_d != '0);
		end
	end

	// read setup: address, dummy length and wrap selection
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_en_q   <= 1'b0;
			rd_addr_q <= 24'h000000;
			dummy_q   <= flash_cmd_pkg::SPI_FAST_DUMMY;
			wrap_rd_q <= 1'b0;
		end else if (cs_n_s) begin
			rd_en_q   <= 1'b0;
		end else begin
			if (rise && st_q == flash_cmd_pkg::ST_CMD && op_full) begin
				wrap_rd_q <= quad_q & is_wrap;
				// single-wire reads keep their fixed dummy length
				dummy_q   <= quad_q ? dummy_pg : flash_cmd_pkg::SPI_FAST_DUMMY;
			end
			if (rise && st_q == flash_cmd_pkg::ST_ADDR
			    && cnt_inc == flash_cmd_pkg::ADDR_BITS) begin
				rd_addr_q <= sh_next[23:0];
				rd_en_q   <= 1'b1;
			end else if (push) begin
				rd_addr_q <= addr_nxt;
			end
		end
	end

	// pin output shifter on sampled falling edges
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			out_sh_q <= 8'h00;
			obit_q   <= 6'h00;
			io_q     <= 4'h0;
			oe_q     <= 4'h0;
		end else if (cs_n_s) begin
			obit_q <= 6'h00;
			oe_q   <= 4'h0;
		end else if (st_q == flash_cmd_pkg::ST_DATA && fall) begin
			// an empty buffer repeats stale data rather than stalling the host
			io_q     <= io_d;
			out_sh_q <= osh_d;
			obit_q   <= (load ? flash_cmd_pkg::OPCODE_BITS : obit_q) - lane;
			oe_q     <= quad_q ? 4'hF : 4'h2;
		end
	end

	assign o_io                     = io_q;
	assign o_io_oe                  = oe_q;
	assign o_four_wire_command_mode = quad_q;
	assign o_dummy_count_field      = rd_param_q[flash_cmd_pkg::DUMMY_FIELD_LSB +: 2];
	assign o_wrap_size_field        = wrap_q;
	assign o_reset_armed            = armed_q;
	assign o_reset_busy             = busy_q;
	assign o_soft_reset             = soft_rst_q;
	assign o_rd_en                  = rd_en_q;
	assign o_rd_addr                = rd_addr_q;
	assign o_rd_ready               = buf_in_ready;

endmodule // flash_quad_mode_reset_ctrl

// *** shared/flash_cmd_pkg.sv ***
// Purpose: shared constants for the flash command interpreter
// Assumes: 250 MHz system clock, serial clock sampled as data
// Notes:   opcodes, field positions, defaults and timing counts
package flash_cmd_pkg;

	// opcodes
	localparam logic [7:0] OP_FAST_READ   = 8'h0B;
	localparam logic [7:0] OP_QUAD_IO_RD  = 8'hEB;
	localparam logic [7:0] OP_WRAP_READ   = 8'h0C;
	localparam logic [7:0] OP_SET_RD_PARM = 8'hC0;
	localparam logic [7:0] OP_SET_WRAP    = 8'h77;
	localparam logic [7:0] OP_QUAD_ENTER  = 8'h38;
	localparam logic [7:0] OP_QUAD_EXIT   = 8'hFF;
	localparam logic [7:0] OP_RESET_ARM   = 8'h66;
	localparam logic [7:0] OP_RESET       = 8'h99;

	// phase lengths in bits or clocks
	localparam logic [5:0] OPCODE_BITS    = 6'h08;
	localparam logic [5:0] ADDR_BITS      = 6'h18;
	localparam logic [5:0] PARAM_BITS     = 6'h08;
	localparam logic [5:0] WRAP_CMD_BITS  = 6'h20;
	localparam logic [5:0] LANE_QUAD      = 6'h04;
	localparam logic [5:0] LANE_SINGLE    = 6'h01;
	localparam logic [5:0] SPI_FAST_DUMMY = 6'h08;
	localparam logic [5:0] DUMMY_MIN      = 6'h02;

	// field positions inside the parameter and wrap bytes
	localparam int DUMMY_FIELD_LSB = 4;
	localparam int WRAP_FIELD_LSB  = 0;
	localparam int SPI_WRAP_LSB    = 4;

	// power-on defaults: 2 dummy clocks, 8-byte wrap
	localparam logic [7:0]  RD_PARAM_RESET  = 8'h00;
	localparam logic [1:0]  WRAP_SIZE_RESET = 2'h0;
	localparam logic [23:0] WRAP_BASE_BYTES = 24'h000008;

	// reset recovery time
	localparam int T_RST_US      = 30;
	localparam int CLK_PERIOD_NS = 4;
	localparam int RST_RECOVERY_CYCLES =
		(T_RST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_CMD,
		ST_ADDR,
		ST_ARG,
		ST_DUMMY,
		ST_DATA,
		ST_SKIP
	} phase_e;

endpackage

// *** tb/flash_ctrl_sva.sv ***
// Purpose: port assertions for the flash command interpreter
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   recovery length arrives through the bind
module flash_ctrl_sva #(
	parameter int RECOVERY_CYCLES = 7500
) (
	// clock and reset
	input wire logic        i_sys_clk,
	input wire logic        i_rst_n,
	// serial link pins
	input wire logic        i_cs_n,
	input wire logic        i_sclk,
	input wire logic [3:0]  i_io,
	input wire logic [3:0]  o_io,
	input wire logic [3:0]  o_io_oe,
	// status and configuration
	input wire logic        i_quad_io_permit_bit,
	input wire logic        o_four_wire_command_mode,
	input wire logic [1:0]  o_dummy_count_field,
	input wire logic [1:0]  o_wrap_size_field,
	input wire logic        o_reset_armed,
	input wire logic        o_reset_busy,
	input wire logic        o_soft_reset,
	// array read stream
	input wire logic        o_rd_en,
	input wire logic [23:0] o_rd_addr,
	input wire logic        i_rd_valid,
	input wire logic [7:0]  i_rd_data,
	input wire logic        o_rd_ready
);
	logic [15:0] busy_cnt_q;
	logic [23:0] win_mask;
	assign win_mask = (24'h000008 << o_wrap_size_field) - 24'h000001;
	// counts consecutive busy cycles so the recovery length can be judged at its end
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
		if (!i_rst_n) busy_cnt_q <= 16'h0000;
		else busy_cnt_q <= o_reset_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);
	sequence s_take;
		o_rd_en && i_rd_valid && o_rd_ready;
	endsequence
	sequence s_cs_idle;
		i_cs_n [*5];
	endsequence
	a_permit_gate: assert property ($rose(o_four_wire_command_mode) |-> i_quad_io_permit_bit)
		else $error("four-wire mode entered without permit");
	a_mode_idle: assert property ($changed(o_four_wire_command_mode) |-> i_cs_n)
		else $error("mode changed inside a frame");
	a_oe_idle: assert property (s_cs_idle |-> o_io_oe == 4'h0)
		else $error("lanes driven while deselected");
	a_arm_busy: assert property ($rose(o_reset_armed) |-> !o_reset_busy)
		else $error("arm taken during recovery");
	a_soft_dflt: assert property (o_soft_reset |-> ##[0:2] (!o_four_wire_command_mode &&
		o_dummy_count_field == 2'h0 && o_wrap_size_field == 2'h0))
		else $error("defaults not restored");
	a_busy_start: assert property (o_soft_reset |-> ##[0:2] o_reset_busy)
		else $error("recovery not started");
	a_busy_len: assert property ($fell(o_reset_busy) |-> busy_cnt_q >= RECOVERY_CYCLES - 1 &&
		busy_cnt_q <= RECOVERY_CYCLES + 1)
		else $error("recovery length wrong");
	a_addr_hold: assert property (o_rd_en && !(i_rd_valid && o_rd_ready) |=>
		(!o_rd_en || $stable(o_rd_addr)))
		else $error("read address moved without a take");
	a_addr_wrap: assert property (s_take ##0 o_four_wire_command_mode |=> (!o_rd_en ||
		(((o_rd_addr ^ $past(o_rd_addr)) & ~win_mask) == 24'h0 && o_rd_addr != $past(o_rd_addr))))
		else $error("read address left its wrap window");
endmodule // flash_ctrl_sva
bind flash_quad_mode_reset_ctrl flash_ctrl_sva #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_sva (.*);

// *** tb/host_model.sv ***
// Purpose: host controller driving chip select, serial clock and lanes
// Assumes: serial clock half period of four system cycles, idle low
// Notes:   lanes nobody drives toggle every cycle rather than hold a value
module host_model (
	// system clock
	input  wire logic       i_sys_clk,
	// device side of the lanes
	input  wire logic [3:0] i_dev_io,
	input  wire logic [3:0] i_dev_oe,
	// link pins towards the device
	output logic            o_cs_n,
	output logic            o_sclk,
	output logic [3:0]      o_io
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] drv_q = 4'h0;
	logic [3:0] drv_oe = 4'h0;
	logic [3:0] flt = 4'h5;
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
	end
	always @(negedge i_sys_clk) flt <= ~flt;
	assign o_io = (i_dev_oe & i_dev_io) | (~i_dev_oe & drv_oe & drv_q)
		| (~i_dev_oe & ~drv_oe & flt);
	task automatic half();
		repeat (4) @(negedge i_sys_clk);
	endtask
	// lanes change while the clock is low, device data is taken just before the rise
	task automatic pulse(input logic [3:0] d, input logic [3:0] oe, output logic [3:0] s);
		drv_q = d;
		drv_oe = oe;
		half();
		s = o_io;
		o_sclk = 1'b1;
		half();
		o_sclk = 1'b0;
	endtask
	task automatic frame(input logic quad, input logic [7:0] t[$], input int ndum,
		input int nrx, output logic [7:0] rx[$]);
		logic [3:0] s;
		logic [7:0] b;
		int w;
		w = quad ? 4 : 1;
		rx = {};
		o_cs_n = 1'b0;
		foreach (t[i])
			for (int u = 0; u < 8; u += w)
				pulse(4'(t[i] >> (8 - w - u)), quad ? 4'hF : 4'h1, s);
		repeat (ndum) pulse(4'h0, 4'h0, s);
		repeat (nrx) begin
			for (int u = 0; u < 8; u += w) begin
				pulse(4'h0, 4'h0, s);
				b = quad ? {b[3:0], s} : {b[6:0], s[1]};
			end
			rx.push_back(b);
		end
		half();
		o_cs_n = 1'b1;
		drv_oe = 4'h0;
		half();
		half();
	endtask
endmodule // host_model

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the flash command interpreter
// Assumes: recovery shortened to 200 cycles, array data derived from address
// Notes:   a small state model predicts mode, fields and arming after each command frame sent by send
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_sys_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_quad_io_permit_bit = 1'b0;
	logic        i_rd_valid = 1'b0;
	logic [7:0]  i_rd_data = 8'h00;
	logic        i_cs_n, i_sclk, o_four_wire_command_mode, o_reset_armed;
	logic        o_reset_busy, o_soft_reset, o_rd_en, o_rd_ready;
	logic [3:0]  i_io, o_io, o_io_oe;
	logic [1:0]  o_dummy_count_field, o_wrap_size_field, m_dum, m_wrap;
	logic [23:0] o_rd_addr;
	logic        m_quad, m_arm, m_busy;
	int          n_mismatch, checked, n_soft;
	flash_quad_mode_reset_ctrl #(.RECOVERY_CYCLES(200)) dut (.*);
	host_model h (.i_sys_clk(i_sys_clk), .i_dev_io(o_io), .i_dev_oe(o_io_oe),
		.o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_io(i_io));
	always #2 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) if (o_soft_reset === 1'b1) n_soft++;
	function automatic logic [7:0] arr(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction
	// the array stalls at random, but pops come many cycles apart so the two-entry buffer refills and does not run dry
	always @(negedge i_sys_clk) begin
		i_rd_valid <= ($urandom % 4) != 0;
		i_rd_data <= arr(o_rd_addr);
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h want %h", $time, what, seen, exp);
		end
	endtask
	task automatic state();
		chk(o_four_wire_command_mode, m_quad, "mode");
		chk(o_dummy_count_field, m_dum, "dummy");
		chk(o_wrap_size_field, m_wrap, "wrap");
		chk(o_reset_armed, m_arm, "arm");
	endtask
	task automatic send(input logic [7:0] t[$]);
		logic [7:0] rx[$];
		h.frame(m_quad, t, 0, 0, rx);
		if (!m_busy) begin
			case (t[0])
				flash_cmd_pkg::OP_SET_RD_PARM: if (m_quad) {m_dum, m_wrap} = {t[1][5:4], t[1][1:0]};
				flash_cmd_pkg::OP_SET_WRAP: if (!m_quad) m_wrap = t[4][5:4];
				flash_cmd_pkg::OP_QUAD_ENTER: if (i_quad_io_permit_bit) m_quad = 1'b1;
				flash_cmd_pkg::OP_QUAD_EXIT: m_quad = 1'b0;
				flash_cmd_pkg::OP_RESET: if (m_arm) {m_quad, m_dum, m_wrap, m_busy} = 6'h01;
				default: ;
			endcase
			m_arm = t[0] == flash_cmd_pkg::OP_RESET_ARM;
		end
		state();
	endtask
	task automatic rd(input logic [23:0] a, input int n);
		logic [7:0] rx[$];
		logic [23:0] m;
		m = (24'h000008 << m_wrap) - 24'h000001;
		h.frame(1'b1, {flash_cmd_pkg::OP_WRAP_READ, a[23:16], a[15:8], a[7:0]},
			2 + 2 * m_dum, n, rx);
		for (int k = 0; k < n; k++)
			chk(rx[k], arr((a & ~m) | ((a + k) & m)), "read");
	endtask
	task automatic wait_idle();
		int i;
		for (i = 0; i < 1000 && o_reset_busy !== 1'b0; i++) @(negedge i_sys_clk);
		if (i == 1000) begin
			chk(o_reset_busy, 24'h0, "recovery");
			print_verdict();
		end
		m_busy = 1'b0;
	endtask
	initial begin
		logic [1:0] r;
		n_mismatch = 0;
		checked = 0;
		n_soft = 0;
		{m_quad, m_arm, m_busy, m_dum, m_wrap} = 7'h00;
		void'($urandom(14));
		repeat (8) @(negedge i_sys_clk);
		i_rst_n = 1'b1;
		repeat (6) @(negedge i_sys_clk);
		state();
		send({flash_cmd_pkg::OP_QUAD_ENTER});
		send({flash_cmd_pkg::OP_SET_RD_PARM, 8'h31});
		r = 2'($urandom);
		send({flash_cmd_pkg::OP_SET_WRAP, 8'h00, 8'h00, 8'h00, {2'h0, r, 4'h0}});
		i_quad_io_permit_bit = 1'b1;
		send({flash_cmd_pkg::OP_QUAD_ENTER});
		for (int d = 0; d < 4; d++) begin
			r = 2'($urandom);
			send({flash_cmd_pkg::OP_SET_RD_PARM, {2'h0, 2'(d), 2'h0, r}});
			rd({18'($urandom), 6'h3C}, 12);
		end
		send({flash_cmd_pkg::OP_RESET_ARM});
		send({flash_cmd_pkg::OP_QUAD_ENTER});
		send({flash_cmd_pkg::OP_RESET});
		wait_idle();
		send({flash_cmd_pkg::OP_RESET_ARM});
		send({flash_cmd_pkg::OP_RESET});
		chk(24'(n_soft), 24'h1, "pulse");
		chk(o_reset_busy, 24'h1, "busy");
		send({flash_cmd_pkg::OP_RESET_ARM});
		wait_idle();
		r = 2'($urandom);
		send({flash_cmd_pkg::OP_SET_WRAP, 8'h00, 8'h00, 8'h00, {2'h0, r, 4'h0}});
		send({flash_cmd_pkg::OP_QUAD_ENTER});
		send({flash_cmd_pkg::OP_QUAD_EXIT});
		send({flash_cmd_pkg::OP_RESET_ARM});
		send({flash_cmd_pkg::OP_RESET});
		chk(24'(n_soft), 24'h2, "pulse");
		wait_idle();
		print_verdict();
	end
endmodule // testbench
